// [hdl/alu_core.sv]
`timescale 1ns/1ps
// combinational datapath: result, new flags, flag write mask, skip decision
module alu_core
(
  // operation
  input wire alu_pkg::alu_op_e op,
  input wire logic [7:0] opnd_a,
  input wire logic [7:0] opnd_b,
  input wire alu_pkg::arith_flags_s flags_in,
  // answer
  output alu_pkg::alu_out_s res
);
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [7:0] sum7;
  logic [8:0] adj;
  logic [7:0] r;
  logic c_out;
  logic hc_out;
  logic ov_out;
  logic [3:0] we;
  logic sk;
  logic add_sel;
  logic sub_sel;
  logic cin;
  logic [7:0] b_eff;

  always_comb
  begin
    add_sel = (op == alu_pkg::OP_ADD) || (op == alu_pkg::OP_ADC);
    sub_sel = (op == alu_pkg::OP_SUB) || (op == alu_pkg::OP_SBC);
    // subtraction as a + ~b + 1, so carry out means no borrow
    b_eff = sub_sel ? ~opnd_b : opnd_b;
    case (op)
      alu_pkg::OP_ADC: cin = flags_in.c;
      alu_pkg::OP_SBC: cin = flags_in.c;
      alu_pkg::OP_SUB: cin = 1'b1;
      default: cin = 1'b0;
    endcase
    sum9 = {1'b0, opnd_a} + {1'b0, b_eff} + {8'h00, cin};
    sum5 = {1'b0, opnd_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
    sum7 = {1'b0, opnd_a[6:0]} + {1'b0, b_eff[6:0]} + {7'h00, cin};
    adj = {1'b0, opnd_a};
    if (flags_in.hc || (opnd_a[3:0] > alu_pkg::NIB_LIMIT))
      adj = adj + {1'b0, alu_pkg::DEC_ADJ_LO};
    if (flags_in.c || (adj[7:4] > alu_pkg::NIB_LIMIT) || adj[8])
      adj = adj + {1'b0, alu_pkg::DEC_ADJ_HI};
    r = opnd_a;
    c_out = flags_in.c;
    hc_out = flags_in.hc;
    ov_out = flags_in.ov;
    we = 4'h0;
    sk = 1'b0;
    case (op)
      alu_pkg::OP_ADD, alu_pkg::OP_ADC, alu_pkg::OP_SUB, alu_pkg::OP_SBC:
      begin
        r = sum9[7:0];
        c_out = sum9[8];
        hc_out = sum5[4];
        ov_out = sum7[7] ^ sum9[8];
        we = 4'hf;
      end
      alu_pkg::OP_DEC_ADJ:
      begin
        r = adj[7:0];
        c_out = adj[8] | flags_in.c;
        we = 4'h1;
      end
      alu_pkg::OP_AND:
      begin
        r = opnd_a & opnd_b;
        we = 4'h4;
      end
      alu_pkg::OP_OR:
      begin
        r = opnd_a | opnd_b;
        we = 4'h4;
      end
      alu_pkg::OP_XOR:
      begin
        r = opnd_a ^ opnd_b;
        we = 4'h4;
      end
      alu_pkg::OP_CPL:
      begin
        r = ~opnd_a;
        we = 4'h4;
      end
      alu_pkg::OP_RL: r = {opnd_a[6:0], opnd_a[7]};
      alu_pkg::OP_RR: r = {opnd_a[0], opnd_a[7:1]};
      alu_pkg::OP_RLC:
      begin
        r = {opnd_a[6:0], flags_in.c};
        c_out = opnd_a[7];
        we = 4'h1;
      end
      alu_pkg::OP_RRC:
      begin
        r = {flags_in.c, opnd_a[7:1]};
        c_out = opnd_a[0];
        we = 4'h1;
      end
      alu_pkg::OP_INC:
      begin
        r = opnd_a + 8'h01;
        we = 4'h4;
      end
      alu_pkg::OP_DEC:
      begin
        r = opnd_a - 8'h01;
        we = 4'h4;
      end
      alu_pkg::OP_SZ: sk = (opnd_a == 8'h00);
      alu_pkg::OP_SNZ: sk = (opnd_a != 8'h00);
      alu_pkg::OP_SIZ:
      begin
        r = opnd_a + 8'h01;
        sk = (r == 8'h00);
      end
      alu_pkg::OP_SDZ:
      begin
        r = opnd_a - 8'h01;
        sk = (r == 8'h00);
      end
      default: r = opnd_a;
    endcase
    res.result = r;
    res.flags.c = c_out;
    res.flags.hc = hc_out;
    res.flags.z = (r == 8'h00);
    res.flags.ov = ov_out;
    res.flag_we = we;
    res.skip = sk;
  end
endmodule : alu_core

// [hdl/alu_pkg.sv]
package alu_pkg;
  localparam int unsigned DATA_W = 8;
  localparam logic [7:0] FLAGS_ADDR = 8'h0a;
  localparam int unsigned C_BIT = 0;
  localparam int unsigned HC_BIT = 1;
  localparam int unsigned Z_BIT = 2;
  localparam int unsigned OV_BIT = 3;
  localparam int unsigned PD_BIT = 4;
  localparam int unsigned TO_BIT = 5;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] FLAGS_IMPL = 8'h3f;
  localparam logic [7:0] DEC_ADJ_LO = 8'h06;
  localparam logic [7:0] DEC_ADJ_HI = 8'h60;
  localparam logic [3:0] NIB_LIMIT = 4'h9;

  typedef enum logic [4:0] {
    OP_NONE = 5'h00,
    OP_ADD = 5'h01,
    OP_ADC = 5'h02,
    OP_SUB = 5'h03,
    OP_SBC = 5'h04,
    OP_DEC_ADJ = 5'h05,
    OP_AND = 5'h06,
    OP_OR = 5'h07,
    OP_XOR = 5'h08,
    OP_CPL = 5'h09,
    OP_RL = 5'h0a,
    OP_RR = 5'h0b,
    OP_RLC = 5'h0c,
    OP_RRC = 5'h0d,
    OP_INC = 5'h0e,
    OP_DEC = 5'h0f,
    OP_SZ = 5'h10,
    OP_SNZ = 5'h11,
    OP_SIZ = 5'h12,
    OP_SDZ = 5'h13,
    OP_PASS = 5'h14
  } alu_op_e;

  typedef struct packed {
    logic ov;
    logic z;
    logic hc;
    logic c;
  } arith_flags_s;

  typedef struct packed {
    logic [7:0] result;
    arith_flags_s flags;
    logic [3:0] flag_we;
    logic skip;
  } alu_out_s;
endpackage : alu_pkg

// [hdl/alu_status_flags.sv]
`timescale 1ns/1ps
// Behaviour
// - operands and results are eight bits wide.
// - add, add with carry, subtract, subtract with borrow, decimal adjust.
// - bitwise and, or, exclusive or, and complement.
// - plain and through-carry rotates, increment and decrement by one.
// - skip on zero, non-zero, increment zero, decrement zero.
// - each flag-affecting operation updates flags from its result.
// - carry bit 0 is carry out or no borrow; through-carry rotates set it.
// - half carry bit 1 is low-nibble carry or no nibble borrow.
// - zero bit 2 set when result is zero.
// - overflow bit 3 is carry into msb xor carry out.
// - powerdown bit 4 cleared at power-up or watchdog clear, set by halt.
// - expired bit 5 cleared at power-up, clear or halt; set on expiry.
// - bits 6 and 7 read as zero.
// - software writes never change powerdown or expired flags.
// - carry, half carry, zero, overflow writable like plain data.
// - flags are never saved automatically on interrupt or call.
// - eight-bit flags register at data address 0x0a.
module alu_status_flags
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // operation from the sequencer
  input wire logic op_valid,
  input wire alu_pkg::alu_op_e op,
  input wire logic [7:0] opnd_a,
  input wire logic [7:0] opnd_b,
  // data memory access
  input wire logic [7:0] mem_addr,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  // system events
  input wire logic halt_exec,
  input wire logic watchdog_clear_instruction,
  input wire logic watchdog_timer_expired,
  // outputs
  output logic [7:0] result_q,
  output logic result_valid_q,
  output logic skip_q,
  output logic [7:0] flags_rdata_q,
  output logic [7:0] alu_flags_q
);
  logic rst_meta_q;
  logic rst_sync_q;
  logic flags_sel;
  alu_pkg::alu_out_s core_out;
  alu_pkg::arith_flags_s cur;
  logic [7:0] flags_d;
  logic [7:0] result_d;
  logic result_valid_d;
  logic skip_d;
  logic [7:0] rdata_d;

  // reset released through two flops
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign cur.c = alu_flags_q[alu_pkg::C_BIT];
  assign cur.hc = alu_flags_q[alu_pkg::HC_BIT];
  assign cur.z = alu_flags_q[alu_pkg::Z_BIT];
  assign cur.ov = alu_flags_q[alu_pkg::OV_BIT];
  assign flags_sel = (mem_addr == alu_pkg::FLAGS_ADDR);

  alu_core u_core
  (
    .op(op),
    .opnd_a(opnd_a),
    .opnd_b(opnd_b),
    .flags_in(cur),
    .res(core_out)
  );

  // flags register carries no stack copy: interrupt and call leave it alone
  always_comb
  begin
    flags_d = alu_flags_q;
    if (mem_wr && flags_sel)
    begin
      // only the four arithmetic flags take written data
      flags_d[alu_pkg::C_BIT] = mem_wdata[alu_pkg::C_BIT];
      flags_d[alu_pkg::HC_BIT] = mem_wdata[alu_pkg::HC_BIT];
      flags_d[alu_pkg::Z_BIT] = mem_wdata[alu_pkg::Z_BIT];
      flags_d[alu_pkg::OV_BIT] = mem_wdata[alu_pkg::OV_BIT];
    end
    // operation flag update follows the store, as a result written to the
    // flags address is itself a flag-affecting operation
    if (op_valid)
    begin
      if (core_out.flag_we[0])
        flags_d[alu_pkg::C_BIT] = core_out.flags.c;
      if (core_out.flag_we[1])
        flags_d[alu_pkg::HC_BIT] = core_out.flags.hc;
      if (core_out.flag_we[2])
        flags_d[alu_pkg::Z_BIT] = core_out.flags.z;
      if (core_out.flag_we[3])
        flags_d[alu_pkg::OV_BIT] = core_out.flags.ov;
    end
    if (halt_exec)
    begin
      flags_d[alu_pkg::PD_BIT] = 1'b1;
      flags_d[alu_pkg::TO_BIT] = 1'b0;
    end
    else if (watchdog_clear_instruction)
    begin
      flags_d[alu_pkg::PD_BIT] = 1'b0;
      flags_d[alu_pkg::TO_BIT] = 1'b0;
    end
    // expiry wins over a same-cycle clear so the event is not lost
    if (watchdog_timer_expired)
      flags_d[alu_pkg::TO_BIT] = 1'b1;
    flags_d = flags_d & alu_pkg::FLAGS_IMPL;
  end

  always_comb
  begin
    result_d = op_valid ? core_out.result : result_q;
    result_valid_d = op_valid;
    skip_d = op_valid & core_out.skip;
    rdata_d = flags_sel ? (flags_d & alu_pkg::FLAGS_IMPL) : 8'h00;
  end

  always_ff @(posedge ref_clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      alu_flags_q <= alu_pkg::FLAGS_RST;
      result_q <= 8'h00;
      result_valid_q <= 1'b0;
      skip_q <= 1'b0;
      flags_rdata_q <= 8'h00;
    end
    else
    begin
      alu_flags_q <= flags_d;
      result_q <= result_d;
      result_valid_q <= result_valid_d;
      skip_q <= skip_d;
      flags_rdata_q <= rdata_d;
    end
  end
endmodule : alu_status_flags

// [verif/alu_flags_props.sv]
`timescale 1ns/1ps
module alu_flags_props
(
  // clock, reset and inputs
  input logic ref_clk,
  input logic nrst,
  input logic op_valid,
  input alu_pkg::alu_op_e op,
  input logic [7:0] opnd_a,
  input logic [7:0] opnd_b,
  input logic [7:0] mem_addr,
  input logic mem_wr,
  input logic halt_exec,
  input logic watchdog_clear_instruction,
  input logic watchdog_timer_expired,
  // outputs
  input logic [7:0] result_q,
  input logic result_valid_q,
  input logic skip_q,
  input logic [7:0] flags_rdata_q,
  input logic [7:0] alu_flags_q
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  logic quiet;
  assign quiet = !(halt_exec | watchdog_clear_instruction |
    watchdog_timer_expired);
  top_zero_a: assert property (alu_flags_q[7:6] == 2'h0)
    else $error("flag bits 7:6 set");
  valid_pulse_a: assert property (op_valid |=> result_valid_q)
    else $error("no result after op");
  skip_pair_a: assert property (
    skip_q |-> result_valid_q && $past(op_valid))
    else $error("skip without op");
  pdto_write_a: assert property (
    mem_wr && quiet |=> $stable(alu_flags_q[5:4]))
    else $error("write changed powerdown or expired");
  halt_pd_a: assert property (
    halt_exec && !watchdog_timer_expired |=> alu_flags_q[5:4] == 2'h1)
    else $error("halt flags wrong");
  clr_both_a: assert property (
    watchdog_clear_instruction && !halt_exec && !watchdog_timer_expired
    |=> alu_flags_q[5:4] == 2'h0)
    else $error("clear left a flag set");
  expire_to_a: assert property (
    watchdog_timer_expired |=> alu_flags_q[5])
    else $error("expiry did not set flag");
  flags_read_a: assert property (
    flags_rdata_q == ($past(mem_addr) == alu_pkg::FLAGS_ADDR ?
    alu_flags_q : 8'h00))
    else $error("flags read data wrong");
  and_zero_a: assert property (
    op_valid && op == alu_pkg::OP_AND |=> result_q ==
    ($past(opnd_a) & $past(opnd_b)) && alu_flags_q[2] == (result_q == 8'h00))
    else $error("and result or zero flag wrong");
endmodule : alu_flags_props

// [verif/seq_model.sv]
`timescale 1ns/1ps
// stands in for the sequencer: one op per falling edge
module seq_model
(
  // clock
  input logic ref_clk,
  // operation
  output logic op_valid,
  output alu_pkg::alu_op_e op,
  output logic [7:0] opnd_a,
  output logic [7:0] opnd_b
);
  initial
  begin
    op_valid = 1'h0;
    op = alu_pkg::OP_NONE;
    opnd_a = 8'h00;
    opnd_b = 8'h00;
  end
  task automatic issue(input alu_pkg::alu_op_e o, input logic [7:0] a,
    input logic [7:0] b);
    @(negedge ref_clk);
    op_valid = 1'h1;
    op = o;
    opnd_a = a;
    opnd_b = b;
  endtask : issue
  // flip released operands so stale data never looks live
  task automatic idle();
    @(negedge ref_clk);
    op_valid = 1'h0;
    opnd_a = ~opnd_a;
    opnd_b = ~opnd_b;
  endtask : idle
endmodule : seq_model

// [verif/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 1'h0;
  logic nrst = 1'h0;
  logic op_valid;
  alu_pkg::alu_op_e op;
  logic [7:0] opnd_a, opnd_b, result_q, flags_rdata_q, alu_flags_q;
  logic [7:0] mem_addr = 8'h0a;
  logic [7:0] mem_wdata = 8'hff;
  logic mem_wr = 1'h0;
  logic halt_exec = 1'h0;
  logic watchdog_clear_instruction = 1'h0;
  logic watchdog_timer_expired = 1'h0;
  logic result_valid_q, skip_q;
  logic [16:0] exp_q[$];
  logic [7:0] fl = 8'h00;
  logic [15:0] lf = 16'hfe5a;
  int n_fail = 0;
  int checks = 0;
  alu_pkg::alu_op_e ot [16] = '{alu_pkg::OP_ADD, alu_pkg::OP_ADC,
    alu_pkg::OP_SUB, alu_pkg::OP_SBC, alu_pkg::OP_DEC_ADJ, alu_pkg::OP_AND,
    alu_pkg::OP_OR, alu_pkg::OP_XOR, alu_pkg::OP_CPL, alu_pkg::OP_RL,
    alu_pkg::OP_RR, alu_pkg::OP_RLC, alu_pkg::OP_RRC, alu_pkg::OP_INC,
    alu_pkg::OP_DEC, alu_pkg::OP_SDZ};
  alu_status_flags i_dut (.*);
  seq_model i_seq (.*);
  initial forever #50 ref_clk = ~ref_clk;
  function automatic logic [15:0] nx(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : nx
  task automatic chk(input logic [16:0] got, input logic [16:0] ex);
    checks++;
    if (got !== ex)
    begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, ex);
    end
  endtask : chk
  task automatic close_out();
    if (n_fail == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out
  // expected values are queued before the op is handed to the sequencer
  task automatic run(input alu_pkg::alu_op_e o, input logic [7:0] a,
    input logic [7:0] b);
    logic [7:0] n;
    logic [8:0] s;
    logic ci;
    logic sk;
    n = (o == alu_pkg::OP_SUB || o == alu_pkg::OP_SBC) ? ~b : b;
    ci = o == alu_pkg::OP_SUB ||
      (fl[0] && (o == alu_pkg::OP_ADC || o == alu_pkg::OP_SBC));
    s = a + n + ci;
    case (o)
      alu_pkg::OP_ADD, alu_pkg::OP_ADC, alu_pkg::OP_SUB, alu_pkg::OP_SBC:
        fl[3:0] = {a[7] == n[7] && s[7] != a[7], s[7:0] == 8'h00,
          a[3:0] + n[3:0] + ci > 5'h0f, s[8]};
      alu_pkg::OP_DEC_ADJ:
      begin
        s = {1'h0, a};
        if (fl[1] || a[3:0] > 4'h9)
          s = s + 9'h006;
        if (fl[0] || s[8:4] > 5'h09)
          s = s + 9'h060;
        fl[0] = fl[0] | s[8];
      end
      alu_pkg::OP_AND: s = {1'h0, a & b};
      alu_pkg::OP_OR: s = {1'h0, a | b};
      alu_pkg::OP_XOR: s = {1'h0, a ^ b};
      alu_pkg::OP_CPL: s = {1'h0, ~a};
      alu_pkg::OP_RL: s = {1'h0, a[6:0], a[7]};
      alu_pkg::OP_RR: s = {1'h0, a[0], a[7:1]};
      alu_pkg::OP_RLC:
      begin
        s = {1'h0, a[6:0], fl[0]};
        fl[0] = a[7];
      end
      alu_pkg::OP_RRC:
      begin
        s = {1'h0, fl[0], a[7:1]};
        fl[0] = a[0];
      end
      alu_pkg::OP_INC, alu_pkg::OP_SIZ: s = {1'h0, a + 8'h01};
      alu_pkg::OP_DEC, alu_pkg::OP_SDZ: s = {1'h0, a - 8'h01};
      default: s = {1'h0, a};
    endcase
    // logic, increment and decrement touch only the zero flag
    if (o inside {alu_pkg::OP_AND, alu_pkg::OP_OR, alu_pkg::OP_XOR,
      alu_pkg::OP_CPL, alu_pkg::OP_INC, alu_pkg::OP_DEC})
      fl[2] = s[7:0] == 8'h00;
    sk = (o inside {alu_pkg::OP_SZ, alu_pkg::OP_SIZ, alu_pkg::OP_SDZ} &&
      s[7:0] == 8'h00) || (o == alu_pkg::OP_SNZ && s[7:0] != 8'h00);
    exp_q.push_back({s[7:0], fl, sk});
    i_seq.issue(o, a, b);
  endtask : run
  task automatic ev(input logic [3:0] v, input logic [7:0] x);
    @(negedge ref_clk);
    {mem_wr, halt_exec, watchdog_clear_instruction,
      watchdog_timer_expired} = v;
    @(negedge ref_clk);
    {mem_wr, halt_exec, watchdog_clear_instruction,
      watchdog_timer_expired} = 4'h0;
    chk({1'h0, flags_rdata_q, alu_flags_q},
      {1'h0, (mem_addr == alu_pkg::FLAGS_ADDR) ? x : 8'h00, x});
  endtask : ev
  always @(negedge ref_clk)
    if (result_valid_q === 1'h1)
      chk({result_q, alu_flags_q, skip_q}, exp_q.pop_front());
  initial
  begin
    repeat (20) @(negedge ref_clk);
    nrst = 1'h1;
    repeat (3) @(negedge ref_clk);
    run(alu_pkg::OP_ADD, 8'h0f, 8'h01);
    run(alu_pkg::OP_SUB, 8'h05, 8'h05);
    run(alu_pkg::OP_ADD, 8'h7f, 8'h01);
    run(alu_pkg::OP_ADD, 8'hff, 8'h01);
    run(alu_pkg::OP_RL, 8'h81, 8'h00);
    run(alu_pkg::OP_SIZ, 8'hff, 8'h00);
    run(alu_pkg::OP_AND, 8'hf0, 8'h0f);
    run(alu_pkg::OP_SZ, 8'h00, 8'h00);
    run(alu_pkg::OP_SNZ, 8'h05, 8'h00);
    run(alu_pkg::OP_SNZ, 8'h00, 8'h00);
    run(alu_pkg::OP_SDZ, 8'h01, 8'h00);
    run(alu_pkg::OP_ADD, 8'h19, 8'h28);
    run(alu_pkg::OP_DEC_ADJ, 8'h41, 8'h00);
    run(alu_pkg::OP_SBC, 8'h10, 8'h01);
    run(alu_pkg::OP_ADC, 8'h10, 8'h20);
    run(alu_pkg::OP_OR, 8'h00, 8'h00);
    run(alu_pkg::OP_XOR, 8'h5a, 8'h5a);
    run(alu_pkg::OP_CPL, 8'h0f, 8'h00);
    run(alu_pkg::OP_RLC, 8'h80, 8'h00);
    run(alu_pkg::OP_RRC, 8'h02, 8'h00);
    run(alu_pkg::OP_RR, 8'h01, 8'h00);
    run(alu_pkg::OP_INC, 8'hff, 8'h00);
    run(alu_pkg::OP_DEC, 8'h01, 8'h00);
    repeat (100)
    begin
      lf = nx(lf);
      run(ot[lf[3:0]], lf[7:0], lf[15:8]);
    end
    i_seq.idle();
    ev(4'h8, 8'h0f);
    ev(4'h4, 8'h1f);
    ev(4'h1, 8'h3f);
    mem_wdata = 8'h00;
    ev(4'h8, 8'h30);
    mem_addr = 8'h05;
    mem_wdata = 8'hff;
    ev(4'h8, 8'h30);
    mem_addr = 8'h0a;
    ev(4'h2, 8'h00);
    chk(17'(exp_q.size()), 17'h0_0000);
    close_out();
  end
  initial
  begin
    #100000;
    n_fail++;
    close_out();
  end
endmodule : tb_top
bind alu_status_flags alu_flags_props i_props (.*);
